// [verilog/ubc_pkg.sv]
// Purpose: Shared constants and types of the serial baud and frame configuration block
// Assumes: 32-bit APB data, one register per aligned word
// Notes: Offsets are byte addresses on the APB
package ubc_pkg;
    localparam int ADDR_W = 8;
    localparam int DIV_W = 13;
    localparam int BDH_W = 5;
    localparam int OS_W = 4;
    localparam int GAP_W = 17;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_BDH = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_BDL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h0C;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [BDH_W-1:0] BDH_RST = 5'h00;
    localparam logic [7:0] BDL_RST = 8'h04;
    localparam logic [7:0] CTRL_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Frame control bit positions
    localparam int CTRL_LOOP = 7;
    localparam int CTRL_HALT = 6;
    localparam int CTRL_RX_SOURCE_SELECT = 5;
    localparam int CTRL_NINE = 4;
    localparam int CTRL_WAKE = 3;
    localparam int CTRL_ILT = 2;
    localparam int CTRL_PE = 1;
    localparam int CTRL_PT = 0;

    // Enable register bit positions
    localparam int EN_TX = 3;
    localparam int EN_RX = 2;

    ////////////////////////////////////////////////////////////////////////
    // Frame and oversampling figures
    localparam logic [OS_W-1:0] OS_LAST = 4'hF;
    localparam logic [GAP_W-1:0] OVERSAMPLE = 17'h00010;
    localparam logic [3:0] FRAME_BITS_8 = 4'hA;
    localparam logic [3:0] FRAME_BITS_9 = 4'hB;

    typedef struct packed {
        logic [BDH_W-1:0] bdh_buf;
        logic [BDH_W-1:0] bdh;
        logic [7:0] bdl;
        logic [7:0] ctrl;
        logic tx_on;
        logic rx_on;
        logic started;
        logic [31:0] rdata;
        logic rx_serial;
        logic txd_out;
        logic txd_oe;
        logic tx_par;
        logic rx_err;
    } ubc_state_t;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [OS_W-1:0] sub;
        logic tick16;
        logic tick;
    } ubc_gen_state_t;
endpackage

// [verilog/ubc_baud_if.sv]
// Purpose: Carries divisor, run control and ticks between config and generator
// Assumes: Single clock domain
// Notes: No clocking block
interface ubc_baud_if;
    logic [ubc_pkg::DIV_W-1:0] divisor;
    logic active;
    logic freeze;
    logic tick16;
    logic tick;
    modport gen(input divisor, input active, input freeze, output tick16, output tick);
    modport cfg(output divisor, output active, output freeze, input tick16, input tick);
endinterface

// [verilog/ubc_baud_gen.sv]
// Purpose: Modulo baud generator, one x16 tick per divisor cycles, bit tick per 16
// Assumes: Divisor held non-zero while active
// Notes: Freeze holds the count so a wait period does not lose phase
module ubc_baud_gen (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Generator side
    ubc_baud_if.gen bus
);
    ubc_pkg::ubc_gen_state_t s;
    ubc_pkg::ubc_gen_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.tick16 = 1'b0;
        next_s.tick = 1'b0;
        if (!bus.active) begin
            next_s.cnt = '0;
            next_s.sub = '0;
        end else if (!bus.freeze) begin
            // A shrinking divisor wraps at once instead of running to the top
            if (s.cnt >= bus.divisor - 13'h0001) begin
                next_s.cnt = '0;
                next_s.tick16 = 1'b1;
                next_s.sub = s.sub + 4'h1;
                next_s.tick = (s.sub == ubc_pkg::OS_LAST);
            end else begin
                next_s.cnt = s.cnt + 13'h0001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bus.tick16 = s.tick16;
    assign bus.tick = s.tick;
endmodule

// [verilog/ubc_uart_cfg.sv]
// Purpose: Baud divisor and frame control registers with pin routing of a UART
// Assumes: APB slave, zero wait states, shift logic lives outside
// Notes: Enable bits sit in a register of their own beside the frame control
//
// The implementer's own choices: the address map and register access over APB.
module ubc_uart_cfg (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ubc_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // System
    input wire logic i_cpu_wait,
    // Serial pins
    input wire logic i_rxd_pin,
    input wire logic i_txd_pin,
    output logic o_txd_pin,
    output logic o_txd_pin_oe,
    // Shift logic side
    input wire logic i_tx_serial,
    input wire logic i_tx_dir,
    input wire logic [8:0] i_tx_char,
    input wire logic [8:0] i_rx_char,
    output logic o_rx_serial,
    output logic o_baud_x16_tick,
    output logic o_baud_tick,
    output logic o_clocks_frozen,
    output logic o_tx_on,
    output logic o_rx_on,
    output logic o_nine_bit,
    output logic o_wake_addr_mark,
    output logic o_idle_after_stop,
    output logic o_parity_enable,
    output logic o_parity_odd,
    output logic [3:0] o_frame_bits,
    output logic [3:0] o_idle_bits,
    output logic o_tx_parity_bit,
    output logic o_rx_parity_err
);
    ubc_pkg::ubc_state_t s;
    ubc_pkg::ubc_state_t next_s;
    ubc_baud_if bus();

    logic setup;
    logic access;
    logic mapped;
    logic wr;
    localparam int DIVW_L = ubc_pkg::DIV_W;
    logic [DIVW_L-1:0] divisor;
    logic loop;
    logic rx_source_select;
    logic nine;
    logic odd;
    logic [7:0] tx_low;
    logic [7:0] rx_low;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign mapped = (i_paddr == ubc_pkg::OFS_BDH) || (i_paddr == ubc_pkg::OFS_BDL)
        || (i_paddr == ubc_pkg::OFS_CTRL) || (i_paddr == ubc_pkg::OFS_ENABLE);
    assign wr = access && i_pwrite && mapped;
    assign o_pready = 1'b1;
    assign o_pslverr = access && !mapped;
    assign o_prdata = s.rdata;

    assign divisor = {s.bdh, s.bdl};
    assign loop = s.ctrl[ubc_pkg::CTRL_LOOP];
    assign rx_source_select = s.ctrl[ubc_pkg::CTRL_RX_SOURCE_SELECT];
    assign nine = s.ctrl[ubc_pkg::CTRL_NINE];
    assign odd = s.ctrl[ubc_pkg::CTRL_PT];
    // Parity bit sits at bit 7 in 8-bit mode, so only bits below it count for transmit; the receive check takes bit 7 too
    assign tx_low = nine ? i_tx_char[7:0] : {1'b0, i_tx_char[6:0]};
    assign rx_low = nine ? i_rx_char[7:0] : i_rx_char[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s = s;
        if (setup) begin
            next_s.rdata = '0;
            // Committed divisor only, the buffered high byte stays hidden
            unique case (i_paddr)
                ubc_pkg::OFS_BDH: next_s.rdata[ubc_pkg::BDH_W-1:0] = s.bdh;
                ubc_pkg::OFS_BDL: next_s.rdata[7:0] = s.bdl;
                ubc_pkg::OFS_CTRL: next_s.rdata[7:0] = s.ctrl;
                ubc_pkg::OFS_ENABLE: begin
                    next_s.rdata[ubc_pkg::EN_TX] = s.tx_on;
                    next_s.rdata[ubc_pkg::EN_RX] = s.rx_on;
                end
                default: next_s.rdata = '0;
            endcase
        end
        if (wr) begin
            unique case (i_paddr)
                ubc_pkg::OFS_BDH: next_s.bdh_buf = i_pwdata[ubc_pkg::BDH_W-1:0];
                ubc_pkg::OFS_BDL: begin
                    next_s.bdl = i_pwdata[7:0];
                    next_s.bdh = s.bdh_buf;
                end
                ubc_pkg::OFS_CTRL: next_s.ctrl = i_pwdata[7:0];
                ubc_pkg::OFS_ENABLE: begin
                    next_s.tx_on = i_pwdata[ubc_pkg::EN_TX];
                    next_s.rx_on = i_pwdata[ubc_pkg::EN_RX];
                    if (i_pwdata[ubc_pkg::EN_TX] || i_pwdata[ubc_pkg::EN_RX]) begin
                        next_s.started = 1'b1;
                    end
                end
                default: next_s.started = s.started;
            endcase
        end
        // Receiver source follows the loop mode
        if (loop && !rx_source_select) begin
            next_s.rx_serial = i_tx_serial;
        end else if (loop) begin
            next_s.rx_serial = i_txd_pin;
        end else begin
            next_s.rx_serial = i_rxd_pin;
        end
        next_s.txd_out = i_tx_serial;
        // Internal loopback leaves the pin to the port; single wire obeys direction
        next_s.txd_oe = s.tx_on && !(loop && !rx_source_select) && (!loop || i_tx_dir);
        next_s.tx_par = (^tx_low) ^ odd;
        next_s.rx_err = s.ctrl[ubc_pkg::CTRL_PE]
            && (((^rx_low) ^ (nine && i_rx_char[8])) != odd);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s.bdh_buf <= ubc_pkg::BDH_RST;
            s.bdh <= ubc_pkg::BDH_RST;
            s.bdl <= ubc_pkg::BDL_RST;
            s.ctrl <= ubc_pkg::CTRL_RST;
            s.tx_on <= 1'b0;
            s.rx_on <= 1'b0;
            s.started <= 1'b0;
            s.rdata <= '0;
            s.rx_serial <= 1'b1;
            s.txd_out <= 1'b1;
            s.txd_oe <= 1'b0;
            s.tx_par <= 1'b0;
            s.rx_err <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Baud generator
    assign bus.divisor = divisor;
    assign bus.active = s.started && (divisor != '0);
    assign bus.freeze = s.ctrl[ubc_pkg::CTRL_HALT] && i_cpu_wait;

    ubc_baud_gen u_gen (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .bus(bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_baud_x16_tick = bus.tick16;
    assign o_baud_tick = bus.tick;
    assign o_clocks_frozen = bus.freeze;
    assign o_rx_serial = s.rx_serial;
    assign o_txd_pin = s.txd_out;
    assign o_txd_pin_oe = s.txd_oe;
    assign o_tx_on = s.tx_on;
    assign o_rx_on = s.rx_on;
    assign o_nine_bit = nine;
    assign o_wake_addr_mark = s.ctrl[ubc_pkg::CTRL_WAKE];
    assign o_idle_after_stop = s.ctrl[ubc_pkg::CTRL_ILT];
    assign o_parity_enable = s.ctrl[ubc_pkg::CTRL_PE];
    assign o_parity_odd = odd;
    assign o_frame_bits = nine ? ubc_pkg::FRAME_BITS_9 : ubc_pkg::FRAME_BITS_8;
    assign o_idle_bits = nine ? ubc_pkg::FRAME_BITS_9 : ubc_pkg::FRAME_BITS_8;
    assign o_tx_parity_bit = s.tx_par;
    assign o_rx_parity_err = s.rx_err;

    ////////////////////////////////////////////////////////////////////////
    // Checks; the rate helper measures the bit tick period over a steady run
    logic [ubc_pkg::GAP_W-1:0] gap;
    logic steady;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap <= '0;
            steady <= 1'b0;
        end else begin
            if (bus.tick) begin
                gap <= 17'h00001;
            end else begin
                gap <= gap + 17'h00001;
            end
            if (!bus.active || bus.freeze || (divisor != $past(divisor))) begin
                steady <= 1'b0;
            end else if (bus.tick) begin
                steady <= 1'b1;
            end
        end
    end

    property p_commit;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr && i_paddr == ubc_pkg::OFS_BDL) |=>
            divisor == {$past(s.bdh_buf), $past(i_pwdata[7:0])};
    endproperty
    a_commit: assert property (p_commit) else $error("divisor not committed");

    property p_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr && i_paddr == ubc_pkg::OFS_BDH) |=> $stable(divisor);
    endproperty
    a_hold: assert property (p_hold) else $error("high byte write changed divisor");

    property p_zero_stop;
        @(posedge i_clk) disable iff (!i_rst_n)
        (divisor == '0) [*2] |-> !o_baud_x16_tick && !o_baud_tick;
    endproperty
    a_zero_stop: assert property (p_zero_stop) else $error("ticks with zero divisor");

    localparam logic [ubc_pkg::GAP_W-1:0] OVERSAMPLE_L = ubc_pkg::OVERSAMPLE;
    property p_rate;
        @(posedge i_clk) disable iff (!i_rst_n)
        (bus.tick && steady && $stable(divisor) && bus.active && !bus.freeze) |->
            gap == OVERSAMPLE_L * {4'h0, divisor};
    endproperty
    a_rate: assert property (p_rate) else $error("bit period wrong");

    property p_idle_reset;
        @(posedge i_clk) disable iff (!i_rst_n)
        !s.started |-> !o_baud_x16_tick && !bus.active;
    endproperty
    a_idle_reset: assert property (p_idle_reset) else $error("generator ran early");

    property p_loop;
        @(posedge i_clk) disable iff (!i_rst_n)
        (loop && !rx_source_select) |=> o_rx_serial == $past(i_tx_serial) && !o_txd_pin_oe;
    endproperty
    a_loop: assert property (p_loop) else $error("internal loopback wrong");

    property p_duplex;
        @(posedge i_clk) disable iff (!i_rst_n)
        !loop |=> o_rx_serial == $past(i_rxd_pin) && o_txd_pin == $past(i_tx_serial);
    endproperty
    a_duplex: assert property (p_duplex) else $error("full duplex routing wrong");

    property p_single;
        @(posedge i_clk) disable iff (!i_rst_n)
        (loop && rx_source_select) |=> o_rx_serial == $past(i_txd_pin) && o_txd_pin == $past(i_tx_serial);
    endproperty
    a_single: assert property (p_single) else $error("single wire routing wrong");

    property p_freeze;
        @(posedge i_clk) disable iff (!i_rst_n)
        bus.freeze [*2] |-> !o_baud_x16_tick;
    endproperty
    a_freeze: assert property (p_freeze) else $error("ticks while frozen");

    property p_frame;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_frame_bits == (o_nine_bit ? ubc_pkg::FRAME_BITS_9 : ubc_pkg::FRAME_BITS_8);
    endproperty
    a_frame: assert property (p_frame) else $error("frame length wrong");

    property p_parity;
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 $stable(s.ctrl) |->
            ((nine ? ^$past(i_tx_char[7:0]) : ^$past(i_tx_char[6:0])) ^ o_tx_parity_bit) == odd;
    endproperty
    a_parity: assert property (p_parity) else $error("parity bit wrong");

    property p_oe;
        @(posedge i_clk) disable iff (!i_rst_n)
        !s.tx_on |=> !o_txd_pin_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("pin driven while transmitter off");

    property p_readback;
        @(posedge i_clk) disable iff (!i_rst_n)
        (setup && !wr && i_paddr == ubc_pkg::OFS_BDH) |=>
            o_prdata == {27'h0000000, $past(s.bdh)};
    endproperty
    a_readback: assert property (p_readback) else $error("read shows pending byte");

    property p_cov_commit;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr && i_paddr == ubc_pkg::OFS_BDH) ##[1:20] (wr && i_paddr == ubc_pkg::OFS_BDL);
    endproperty
    c_commit: cover property (p_cov_commit);

    property p_cov_tick;
        @(posedge i_clk) disable iff (!i_rst_n)
        bus.tick && steady;
    endproperty
    c_tick: cover property (p_cov_tick);

    property p_cov_single;
        @(posedge i_clk) disable iff (!i_rst_n)
        loop && rx_source_select && o_txd_pin_oe;
    endproperty
    c_single: cover property (p_cov_single);
endmodule

// [verilog/ubc_end.sv]
// Purpose: none
// Assumes: none
// Notes: none

// [verification/ubc_remote_dev.sv]
// Purpose: Remote serial device seen across the receive pin and the transmit line
// Assumes: Bench chooses the levels that the remote device puts on its wires
// Notes: Remote drives the shared line whenever the block lets go, so it never floats
module ubc_remote_dev (
    // Block pins
    input wire logic i_dut_txd,
    input wire logic i_dut_oe,
    // Bench control
    input wire logic i_rx_level,
    input wire logic i_line_level,
    // Wires
    output logic o_rxd_pin,
    output logic o_txd_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    assign o_rxd_pin = i_rx_level;
    assign o_txd_wire = i_dut_oe ? i_dut_txd : i_line_level;
endmodule

// [verification/uart_baud_and_frame_config_tb.sv]
// Purpose: Self-checking bench for the baud divisor and frame control block
// Assumes: Zero wait APB, routing and parity outputs one cycle late
// Notes: Short divisors keep tick windows brief
module uart_baud_and_frame_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_rst_n, psel, penable, pwrite, cpu_wait, tx_serial, tx_dir;
    logic rx_level, line_level, errv;
    logic [7:0] paddr;
    logic [31:0] pwdata, rdv, prdata;
    logic [8:0] tx_char, rx_char;
    logic pready, pslverr, txd_pin, txd_oe, rxd_pin, txd_wire, rx_serial, x16, btick;
    logic frozen, tx_on, rx_on, nine, wake, idle_count_start_select, pe, odd, tx_par, rx_err;
    logic [3:0] frame_bits, idle_bits;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int c16 = 0;
    int cb = 0;
    ////////////////////////////////////////////////////////////////////////
    ubc_uart_cfg DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cpu_wait(cpu_wait), .i_rxd_pin(rxd_pin),
        .i_txd_pin(txd_wire), .o_txd_pin(txd_pin), .o_txd_pin_oe(txd_oe),
        .i_tx_serial(tx_serial), .i_tx_dir(tx_dir), .i_tx_char(tx_char), .i_rx_char(rx_char),
        .o_rx_serial(rx_serial), .o_baud_x16_tick(x16), .o_baud_tick(btick),
        .o_clocks_frozen(frozen), .o_tx_on(tx_on), .o_rx_on(rx_on), .o_nine_bit(nine),
        .o_wake_addr_mark(wake), .o_idle_after_stop(idle_count_start_select), .o_parity_enable(pe),
        .o_parity_odd(odd), .o_frame_bits(frame_bits), .o_idle_bits(idle_bits),
        .o_tx_parity_bit(tx_par), .o_rx_parity_err(rx_err));
    ubc_remote_dev REMOTE (.i_dut_txd(txd_pin), .i_dut_oe(txd_oe), .i_rx_level(rx_level),
        .i_line_level(line_level), .o_rxd_pin(rxd_pin), .o_txd_wire(txd_wire));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // Counted mid-cycle so the tick registers have settled
    always @(negedge i_clk) begin
        if (x16 === 1'b1) c16++;
        if (btick === 1'b1) cb++;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1) @(posedge i_clk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(rdv, e);
    endtask
    task automatic st(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    task automatic ticks(input int n, input int e16, input int eb);
        int s16;
        int sb;
        @(posedge i_clk);
        s16 = c16;
        sb = cb;
        repeat (n) @(posedge i_clk);
        chk(c16 - s16, e16);
        chk(cb - sb, eb);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] fb;
        logic ep, eo, ex;
        {i_rst_n, psel, penable, pwrite, cpu_wait, tx_dir} = 6'h00;
        {tx_serial, rx_level, line_level} = 3'h7;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        tx_char = 9'h0B3;
        rx_char = 9'h1B3;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdc(ubc_pkg::OFS_BDH, 32'h00000000);
        rdc(ubc_pkg::OFS_BDL, 32'h00000004);
        rdc(ubc_pkg::OFS_CTRL, 32'h00000000);
        rdc(ubc_pkg::OFS_ENABLE, 32'h00000000);
        apb(1'b0, 8'h10, 32'h00000000);
        chk(rdv, 32'h00000000);
        chk({31'h0, errv}, 32'h00000001);
        ticks(64, 0, 0);
        wr(ubc_pkg::OFS_BDH, 32'h00000001);
        rdc(ubc_pkg::OFS_BDH, 32'h00000000);
        wr(ubc_pkg::OFS_BDL, 32'h00000002);
        rdc(ubc_pkg::OFS_BDH, 32'h00000001);
        rdc(ubc_pkg::OFS_BDL, 32'h00000002);
        wr(ubc_pkg::OFS_BDH, 32'h00000000);
        $display("test reset_and_divisor finished");
        wr(ubc_pkg::OFS_ENABLE, 32'h00000008);
        rdc(ubc_pkg::OFS_ENABLE, 32'h00000008);
        for (int d = 1; d <= 3; d++) begin
            wr(ubc_pkg::OFS_BDL, d);
            st(40);
            ticks(32 * d, 32, 2);
        end
        wr(ubc_pkg::OFS_CTRL, 32'h00000040);
        cpu_wait <= 1'b1;
        st(2);
        chk({31'h0, frozen}, 32'h00000001);
        ticks(96, 0, 0);
        wr(ubc_pkg::OFS_CTRL, 32'h00000000);
        st(2);
        chk({31'h0, frozen}, 32'h00000000);
        ticks(96, 32, 2);
        cpu_wait <= 1'b0;
        wr(ubc_pkg::OFS_BDL, 32'h00000000);
        st(4);
        ticks(96, 0, 0);
        $display("test baud_generator finished");
        for (int b = 0; b < 5; b++) begin
            wr(ubc_pkg::OFS_CTRL, 32'h1 << b);
            rdc(ubc_pkg::OFS_CTRL, 32'h1 << b);
            st(1);
            fb = (b == ubc_pkg::CTRL_NINE) ? 4'hB : 4'hA;
            chk({nine, wake, idle_count_start_select, pe, odd}, 32'h1 << b);
            chk(frame_bits, fb);
            chk(idle_bits, fb);
        end
        for (int m = 0; m < 4; m++) begin
            wr(ubc_pkg::OFS_CTRL, {27'h0, m[1], 2'b00, 1'b1, m[0]});
            st(2);
            eo = m[0];
            ep = m[1] ? (^tx_char[7:0]) ^ eo : (^tx_char[6:0]) ^ eo;
            ex = m[1] ? (^rx_char[8:0]) ^ eo : (^rx_char[7:0]) ^ eo;
            chk({31'h0, tx_par}, {31'h0, ep});
            chk({31'h0, rx_err}, {31'h0, ex});
        end
        wr(ubc_pkg::OFS_CTRL, 32'h00000000);
        st(2);
        chk({31'h0, rx_err}, 32'h00000000);
        $display("test frame_control finished");
        for (int m = 0; m < 4; m++) begin
            wr(ubc_pkg::OFS_CTRL, {24'h0, m[1], 1'b0, m[0], 5'h00});
            for (int k = 0; k < 16; k++) begin
                @(posedge i_clk);
                {tx_dir, line_level, rx_level, tx_serial} <= k[3:0];
                st(3);
                eo = m[1] ? (m[0] ? k[3] : 1'b0) : 1'b1;
                ex = !m[1] ? k[1] : ((m[0] && !k[3]) ? k[2] : k[0]);
                chk({31'h0, txd_oe}, {31'h0, eo});
                chk({31'h0, rx_serial}, {31'h0, ex});
                if (eo) chk({31'h0, txd_pin}, {31'h0, k[0]});
            end
        end
        wr(ubc_pkg::OFS_CTRL, 32'h00000000);
        wr(ubc_pkg::OFS_ENABLE, 32'h00000004);
        st(2);
        chk({30'h0, tx_on, rx_on}, 32'h00000001);
        chk({31'h0, txd_oe}, 32'h00000000);
        $display("test pin_routing finished");
        // A second reset must clear the started state so the generator idles again
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdc(ubc_pkg::OFS_BDL, 32'h00000004);
        rdc(ubc_pkg::OFS_ENABLE, 32'h00000000);
        ticks(64, 0, 0);
        $display("test mid_reset finished");
        final_report();
    end
endmodule
